//--- common/spi_flash_pkg.sv
// Constants and types of the sensor serial register port.
// Assumes a 100 MHz system clock and a mode-3 serial master.
`default_nettype none
package spi_flash_pkg;
    localparam int WORD_W   = 16;
    localparam int NUM_REGS = 32;
    localparam int IDX_W    = 5;

    // Register indices (byte address divided by two)
    localparam logic [IDX_W-1:0] IDX_FLASH_CNT  = 5'h00;
    localparam logic [IDX_W-1:0] IDX_NULL_X     = 5'h01;
    localparam logic [IDX_W-1:0] IDX_NULL_Y     = 5'h02;
    localparam logic [IDX_W-1:0] IDX_NULL_Z     = 5'h03;
    localparam logic [IDX_W-1:0] IDX_CAPT_BUFFX = 5'h0a;
    localparam logic [IDX_W-1:0] IDX_CAPT_BUFFY = 5'h0b;
    localparam logic [IDX_W-1:0] IDX_CAPT_BUFFZ = 5'h0c;
    localparam logic [IDX_W-1:0] IDX_CAPT_PNTR  = 5'h0d;
    localparam logic [IDX_W-1:0] IDX_ALM_MAGX   = 5'h10;
    localparam logic [IDX_W-1:0] IDX_ALM_MAGY   = 5'h11;
    localparam logic [IDX_W-1:0] IDX_ALM_MAGZ   = 5'h12;
    localparam logic [IDX_W-1:0] IDX_AVG_CNT    = 5'h1c;
    localparam logic [IDX_W-1:0] IDX_GLOBAL_CMD = 5'h1f;
    localparam logic [IDX_W-1:0] IDX_LAST       = 5'h1f;

    // One bit per register index
    localparam logic [NUM_REGS-1:0] FLASH_BACKED = 32'h1a1f_c3ef;
    localparam logic [NUM_REGS-1:0] WRITABLE     = 32'h1e1f_e00e;

    // Global command bits, position inside their byte
    localparam int FLASH_UPDATE_BIT = 4;
    localparam int RESTART_BIT      = 7;

    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [3:0]        BIT_LAST  = 4'hf;
    localparam logic [3:0]        SHIFT_LIM = 4'h8;

    // Reset recovery
    localparam int CLK_HZ       = 100_000_000;
    localparam int RECOVERY_MS  = 54;
    localparam int RECOVERY_CYC = RECOVERY_MS * (CLK_HZ / 1000);

    typedef struct packed {
        logic       wr;
        logic [5:0] addr;
        logic       hi_byte;
        logic [7:0] data;
    } frame_t;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] x;
        logic [WORD_W-1:0] y;
        logic [WORD_W-1:0] z;
    } sample_t;

    typedef enum logic [3:0] {
        ST_BOOT  = 4'h1,
        ST_WAIT  = 4'h2,
        ST_RUN   = 4'h4,
        ST_FLASH = 4'h8
    } state_t;
endpackage
`default_nettype wire

//--- rtl/spi_register_port.sv
// Serial slave port, dual SRAM/flash register file and sample pipe.
// Assumes a mode-3 master that leaves at least a few system clocks
// between frames; sclk may stop while select is high.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Select low enables the port; select high clears the bit counters, receive shift register and data out.
// - Output enable follows select low, three system clocks late.
// - Input bits are sampled on rising serial clock edges.
// - Output bits change on falling serial clock edges.
// - Each 16-bit register has an upper and a lower byte address.
// - Output carries only the word that the previous frame requested.
// - SRAM registers steer operation and take master writes to writable registers while running.
// - Flash copy of backed registers only on global flash-update bit.
// - After reset flash loads into SRAM before sampling begins.
// - Samples get offset, filtering, alarm check, then the capture buffer.
// - Sampling runs by itself with no master activity.
// - Mode 3, 16-bit frames, most significant bit first.
// - Read takes two frames; second returns data and may request again.
// - Writes carry one byte per frame.
// - Reset pin or global bit 7 restarts with about 54 ms recovery.
module spi_register_port
    import spi_flash_pkg::*;
#(
    parameter int RECOVERY_CYCLES = spi_flash_pkg::RECOVERY_CYC,
    parameter int CAPT_DEPTH      = 1024
)
(
    // System
    input  wire logic                 clock,
    input  wire logic                 rstn,
    // Serial link
    input  wire logic                 sclk,
    input  wire logic                 cs_n,
    input  wire logic                 din,
    output var  logic                 dout,
    output var  logic                 dout_oe,
    // Sensor samples
    input  wire spi_flash_pkg::sample_t sample,
    // Status lines
    output var  logic                 digital_line_one,
    output var  logic                 digital_line_two
);
    import spi_flash_pkg::*;

    localparam int PTR_W = $clog2(CAPT_DEPTH);
    localparam int CNT_W = $clog2(RECOVERY_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_END = CNT_W'(RECOVERY_CYCLES - 1);

    generate
        if (CAPT_DEPTH < 2 || (1 << PTR_W) != CAPT_DEPTH)
            $error("CAPT_DEPTH must be a power of two of at least 2");
        if (RECOVERY_CYCLES < 1)
            $error("RECOVERY_CYCLES must be at least 1");
        if (PTR_W > WORD_W)
            $error("CAPT_DEPTH must fit the 16-bit capture pointer");
    endgenerate

    typedef struct packed {
        state_t            st;
        logic [IDX_W-1:0]  idx;
        logic [CNT_W-1:0]  wait_cnt;
        logic              cs_s1;
        logic              cs_s2;
        logic              tgl_s1;
        logic              tgl_s2;
        logic              tgl_s3;
        logic              oe;
        logic [WORD_W-1:0] tx_word;
        logic [WORD_W-1:0] fx;
        logic [WORD_W-1:0] fy;
        logic [WORD_W-1:0] fz;
        logic [PTR_W-1:0]  wr_ptr;
        logic              busy;
        logic              alarm;
    } sys_t;

    localparam sys_t SYS_RESET = '{
        st: ST_BOOT, idx: '0, wait_cnt: '0, cs_s1: 1'b1, cs_s2: 1'b1,
        tgl_s1: 1'b0, tgl_s2: 1'b0, tgl_s3: 1'b0, oe: 1'b0,
        tx_word: WORD_ZERO, fx: WORD_ZERO, fy: WORD_ZERO, fz: WORD_ZERO,
        wr_ptr: '0, busy: 1'b1, alarm: 1'b0};

    sys_t s;
    sys_t next_s;

    // Register file and its nonvolatile copy; flash has no reset, so
    // backed words stay unknown until written and then saved by a flash update
    logic [WORD_W-1:0]   sram  [NUM_REGS];
    logic [WORD_W-1:0]   flash [NUM_REGS];
    logic [3*WORD_W-1:0] capt  [CAPT_DEPTH];

    logic                sram_we;
    logic [IDX_W-1:0]    sram_idx;
    logic [WORD_W-1:0]   sram_wdata;
    logic                flash_we;
    logic [WORD_W-1:0]   flash_wdata;
    logic                capt_we;
    logic [3*WORD_W-1:0] capt_wdata;

    // Link side
    logic [3:0]          rise_cnt;
    logic [WORD_W-2:0]   rx_shift;
    logic [WORD_W-1:0]   link_word;
    logic                link_tgl;
    logic [3:0]          fall_cnt;

    // One filter step: offset, then first-order low-pass
    function automatic logic [WORD_W-1:0] filt_step(
        input logic [WORD_W-1:0] acc,
        input logic [WORD_W-1:0] raw,
        input logic [WORD_W-1:0] nul,
        input logic [3:0]        sh
    );
        logic signed [WORD_W:0] d;
        // One extra sign bit; raw plus offset minus acc can still wrap at the extremes
        d = $signed({raw[WORD_W-1], raw}) + $signed({nul[WORD_W-1], nul})
            - $signed({acc[WORD_W-1], acc});
        d = d >>> sh;
        return acc + d[WORD_W-1:0];
    endfunction

    // Magnitude above a nonzero threshold
    function automatic logic over_mag(
        input logic [WORD_W-1:0] v,
        input logic [WORD_W-1:0] mag
    );
        logic [WORD_W-1:0] a;
        a = v[WORD_W-1] ? (~v + 16'h0001) : v;
        return (mag != WORD_ZERO) && (a > mag);
    endfunction

    // Frame receive on rising edges, cleared by select high
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            rise_cnt <= 4'h0;
            rx_shift <= '0;
        end
        else
        begin
            rise_cnt <= rise_cnt + 4'h1;
            rx_shift <= {rx_shift[WORD_W-3:0], din};
        end
    end

    // Whole frame handed over with a toggle; the word is written with
    // the flip, and the system side only reads it two flip-flops later
    // when it has long settled
    always_ff @(posedge sclk or negedge rstn)
    begin
        if (!rstn)
        begin
            link_word <= WORD_ZERO;
            link_tgl  <= 1'b0;
        end
        else if (!cs_n && rise_cnt == BIT_LAST)
        begin
            link_word <= {rx_shift, din};
            link_tgl  <= ~link_tgl;
        end
    end

    // Transmit on falling edges, word held stable during each frame.
    // The word crosses without a synchroniser: it only changes a few
    // system clocks after a frame ends, long before the next one starts.
    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            fall_cnt <= 4'h0;
            dout     <= 1'b0;
        end
        else
        begin
            fall_cnt <= fall_cnt + 4'h1;
            dout     <= s.tx_word[BIT_LAST - fall_cnt];
        end
    end

    always_comb
    begin
        frame_t                fr;
        logic                  frame_evt;
        logic [IDX_W-1:0]      ri;
        logic [PTR_W-1:0]      rp;
        logic [3:0]            sh;
        logic [WORD_W-1:0]     nx;
        logic [WORD_W-1:0]     ny;
        logic [WORD_W-1:0]     nz;
        next_s      = s;
        sram_we     = 1'b0;
        sram_idx    = s.idx;
        sram_wdata  = WORD_ZERO;
        flash_we    = 1'b0;
        flash_wdata = sram[s.idx];
        capt_we     = 1'b0;
        capt_wdata  = '0;
        fr          = frame_t'(link_word);
        // Register index: low five bits of the address field, byte-select bit dropped
        ri          = fr.addr[IDX_W-1:0];
        frame_evt   = s.tgl_s2 ^ s.tgl_s3;
        rp          = sram[IDX_CAPT_PNTR][PTR_W-1:0];
        sh          = sram[IDX_AVG_CNT][3:0];
        if (sh > SHIFT_LIM)
            sh = SHIFT_LIM;
        nx = filt_step(s.fx, sample.x, sram[IDX_NULL_X], sh);
        ny = filt_step(s.fy, sample.y, sram[IDX_NULL_Y], sh);
        nz = filt_step(s.fz, sample.z, sram[IDX_NULL_Z], sh);

        // Select passes two flip-flops before it steers the enable
        next_s.cs_s1  = cs_n;
        next_s.cs_s2  = s.cs_s1;
        next_s.oe     = ~s.cs_s2;
        next_s.tgl_s1 = link_tgl;
        next_s.tgl_s2 = s.tgl_s1;
        next_s.tgl_s3 = s.tgl_s2;

        case (s.st)
            ST_BOOT:
            begin
                // Flash image into SRAM, unbacked words cleared
                sram_we    = 1'b1;
                sram_wdata = FLASH_BACKED[s.idx] ? flash[s.idx] : WORD_ZERO;
                next_s.idx = s.idx + 5'h01;
                if (s.idx == IDX_LAST)
                begin
                    next_s.st       = ST_WAIT;
                    next_s.wait_cnt = '0;
                end
            end
            ST_WAIT:
            begin
                next_s.wait_cnt = s.wait_cnt + CNT_W'(1);
                if (s.wait_cnt == CNT_END)
                    next_s.st = ST_RUN;
            end
            ST_RUN:
            begin
                if (sample.valid)
                begin
                    next_s.fx     = nx;
                    next_s.fy     = ny;
                    next_s.fz     = nz;
                    capt_we       = 1'b1;
                    capt_wdata    = {nx, ny, nz};
                    next_s.wr_ptr = s.wr_ptr + PTR_W'(1);
                    next_s.alarm  = over_mag(nx, sram[IDX_ALM_MAGX])
                                  | over_mag(ny, sram[IDX_ALM_MAGY])
                                  | over_mag(nz, sram[IDX_ALM_MAGZ]);
                end
                // Frames are acted on only here; any sent while busy are lost
                if (frame_evt)
                begin
                    next_s.tx_word = WORD_ZERO;
                    if (!fr.wr)
                    begin
                        case (ri)
                            IDX_CAPT_BUFFX:
                                next_s.tx_word = capt[rp][3*WORD_W-1:2*WORD_W];
                            IDX_CAPT_BUFFY:
                                next_s.tx_word = capt[rp][2*WORD_W-1:WORD_W];
                            IDX_CAPT_BUFFZ:
                                next_s.tx_word = capt[rp][WORD_W-1:0];
                            IDX_GLOBAL_CMD:
                                next_s.tx_word = WORD_ZERO;
                            default:
                                next_s.tx_word = sram[ri];
                        endcase
                    end
                    else if (ri == IDX_GLOBAL_CMD)
                    begin
                        if (fr.hi_byte && fr.data[FLASH_UPDATE_BIT])
                        begin
                            next_s.st  = ST_FLASH;
                            next_s.idx = '0;
                        end
                        else if (!fr.hi_byte && fr.data[RESTART_BIT])
                        begin
                            next_s.st  = ST_BOOT;
                            next_s.idx = '0;
                        end
                    end
                    else if (WRITABLE[ri])
                    begin
                        sram_we    = 1'b1;
                        sram_idx   = ri;
                        sram_wdata = fr.hi_byte
                                   ? {fr.data, sram[ri][7:0]}
                                   : {sram[ri][15:8], fr.data};
                    end
                end
            end
            ST_FLASH:
            begin
                // Backed words into flash, write count bumped
                flash_we = FLASH_BACKED[s.idx];
                if (s.idx == IDX_FLASH_CNT)
                begin
                    flash_wdata = sram[IDX_FLASH_CNT] + 16'h0001;
                    sram_we     = 1'b1;
                    sram_wdata  = flash_wdata;
                end
                next_s.idx = s.idx + 5'h01;
                if (s.idx == IDX_LAST)
                    next_s.st = ST_RUN;
            end
            default:
            begin
                next_s.st  = ST_BOOT;
                next_s.idx = '0;
            end
        endcase
        // Busy covers every state but normal run
        next_s.busy = (next_s.st != ST_RUN);
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
            s <= SYS_RESET;
        else
            s <= next_s;
        // Memory writes are held off while reset is low
        if (rstn && sram_we)
            sram[sram_idx] <= sram_wdata;
        if (rstn && flash_we)
            flash[s.idx] <= flash_wdata;
        if (rstn && capt_we)
            capt[s.wr_ptr] <= capt_wdata;
    end

    assign dout_oe          = s.oe;
    assign digital_line_one = s.busy;
    assign digital_line_two = s.alarm;
endmodule
`default_nettype wire

//--- test/spi_register_port_props.sv
// Checker for the serial register port, bound to its top module.
// Assumes all properties sample on the system clock.
`timescale 1ns/1ns
`default_nettype none
module spi_port_checker
    import spi_flash_pkg::*;
#(
    parameter int RECOVERY_CYCLES = 20,
    parameter int CAPT_DEPTH      = 16
)
(
    // Watched ports
    input wire logic                   clock,
    input wire logic                   rstn,
    input wire logic                   sclk,
    input wire logic                   cs_n,
    input wire logic                   din,
    input wire logic                   dout,
    input wire logic                   dout_oe,
    input wire spi_flash_pkg::sample_t sample,
    input wire logic                   digital_line_one,
    input wire logic                   digital_line_two
);
    logic [15:0] busy_cnt;

    // Length of the current busy stretch
    always_ff @(posedge clock)
    begin
        if (!rstn || !digital_line_one)
            busy_cnt <= 16'h0000;
        else if (busy_cnt != 16'hffff)
            busy_cnt <= busy_cnt + 16'h0001;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_release; $rose(rstn); endsequence
    sequence s_loading; digital_line_one[*8]; endsequence

    property p_load_first; s_release |-> s_loading; endproperty
    property p_oe_on; (!cs_n)[*4] |-> dout_oe; endproperty
    property p_oe_off; cs_n[*4] |-> !dout_oe; endproperty
    property p_dout_idle; cs_n |-> !dout; endproperty
    property p_dout_fall; !cs_n && $changed(dout) |-> !sclk; endproperty
    property p_busy_min;
        $fell(digital_line_one) |-> busy_cnt >= 16'h001e;
    endproperty
    property p_busy_max;
        digital_line_one |-> int'(busy_cnt) < RECOVERY_CYCLES + 40;
    endproperty
    property p_alarm_cause;
        $changed(digital_line_two) |-> $past(sample.valid);
    endproperty

    a_load_first: assert property (p_load_first)
        else $error("busy dropped right after reset");
    a_oe_on: assert property (p_oe_on)
        else $error("output not enabled while selected");
    a_oe_off: assert property (p_oe_off)
        else $error("output enabled while deselected");
    a_dout_idle: assert property (p_dout_idle)
        else $error("data out not low while deselected");
    a_dout_fall: assert property (p_dout_fall)
        else $error("data out moved off a falling serial edge");
    a_busy_min: assert property (p_busy_min)
        else $error("busy stretch too short");
    a_busy_max: assert property (p_busy_max)
        else $error("busy stretch too long");
    a_alarm_cause: assert property (p_alarm_cause)
        else $error("alarm moved without a sample");
endmodule

bind spi_register_port spi_port_checker #(
    .RECOVERY_CYCLES(RECOVERY_CYCLES),
    .CAPT_DEPTH     (CAPT_DEPTH)
) chk_i (.clock(clock), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(dout_oe), .sample(sample),
    .digital_line_one(digital_line_one),
    .digital_line_two(digital_line_two));
`default_nettype wire

//--- test/spi_master_model.sv
// Mode-3 serial master: 16-bit frames at 8 MHz, sclk idle high.
// Assumes the caller waits out the stall that xfer ends with.
`timescale 1ns/1ns
`default_nettype none
module spi_master_model
(
    // Serial link
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic din,
    input  wire logic miso
);
    initial
    begin
        sclk = 1'b1;
        din  = 1'b0;
        // Select rises after time zero so the port sees a clean edge
        #1;
        cs_n = 1'b1;
    end

    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        cs_n = 1'b0;
        #62;
        for (int i = 15; i >= 0; i--)
        begin
            sclk = 1'b0;
            din  = tx[i];
            #63;
            sclk = 1'b1;
            rx[i] = miso;
            #62;
        end
        #10;
        cs_n = 1'b1;
        // Released line shows no stale level
        din  = ~din;
        #1300;
    endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the serial register port.
// Assumes the master model and the bound checker are compiled before.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import spi_flash_pkg::*;
    logic        clock, rstn, sclk, cs_n, din, dout, dout_oe, busy, alarm;
    sample_t     sample;
    wire         miso;
    int          mismatches = 0;
    int          checks = 0;
    logic [15:0] r;

    assign miso = dout_oe ? dout : 1'bz;

    spi_register_port #(.RECOVERY_CYCLES(20), .CAPT_DEPTH(16))
    spi_register_port_i (.clock(clock), .rstn(rstn), .sclk(sclk),
        .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
        .sample(sample), .digital_line_one(busy), .digital_line_two(alarm));
    spi_master_model spi_master_model_i (.sclk(sclk), .cs_n(cs_n),
        .din(din), .miso(miso));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic xf(input logic [15:0] tx);
        spi_master_model_i.xfer(tx, r);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400)
        begin
            @(negedge clock);
            n++;
        end
        check({15'h0000, busy}, 16'h0000);
    endtask

    task automatic t_bytes();
        xf(16'h8212);
        xf(16'h8334);
        check(r, 16'h0000);
        xf(16'h0200);
        xf(16'h0300);
        check(r, 16'h3412);
        xf(16'h3e00);
        check(r, 16'h3412);
        xf(16'h8855);
        check(r, 16'h0000);
        xf(16'h0800);
        xf(16'h0000);
        check(r, 16'h0000);
    endtask

    task automatic t_flash();
        xf(16'hbf10);
        wait_idle();
        xf(16'h8200);
        xf(16'h0200);
        xf(16'h0000);
        check(r, 16'h3400);
        xf(16'hbe80);
        wait_idle();
        xf(16'h0200);
        xf(16'h0000);
        check(r, 16'h3412);
    endtask

    task automatic t_pin_reset();
        @(negedge clock);
        rstn = 1'b0;
        repeat (2) @(negedge clock);
        check({15'h0000, busy}, 16'h0001);
        rstn = 1'b1;
        @(negedge clock);
        check({15'h0000, busy}, 16'h0001);
        wait_idle();
        xf(16'h0300);
        xf(16'h0000);
        check(r, 16'h3412);
    endtask

    task automatic t_alarm();
        xf(16'h8200);
        xf(16'h8300);
        xf(16'ha010);
        // Backed words reload unknown: clear thresholds and averaging
        xf(16'ha100);
        xf(16'ha200);
        xf(16'ha300);
        xf(16'ha400);
        xf(16'ha500);
        xf(16'hb800);
        @(negedge clock);
        sample = {1'b1, 16'h0020, 32'h0000_0000};
        @(negedge clock);
        sample.valid = 1'b0;
        check({15'h0000, alarm}, 16'h0001);
        sample = {1'b1, 16'h0005, 32'h0000_0000};
        @(negedge clock);
        sample.valid = 1'b0;
        check({15'h0000, alarm}, 16'h0000);
        xf(16'h1400);
        xf(16'h9a01);
        check(r, 16'h0020);
        xf(16'h1400);
        xf(16'h0000);
        check(r, 16'h0005);
    endtask

    initial
    begin
        rstn = 1'b0;
        sample = '0;
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        wait_idle();
        t_bytes();
        t_flash();
        t_pin_reset();
        t_alarm();
        stop_test();
    end

    initial
    begin
        repeat (60000) @(posedge clock);
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire
